// [logic/osc_top.sv]
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: Each direct output has a composite source selector; default code 128 is constant off.
// R2: Composite source inversion per direct output: 0 passes, 1 inverts; default 0.
// R3: Each user output has a source A selector, default constant off.
// R4: Source A inversion per user output: 0 passes, 1 inverts; default 0.
// R5: Each user output has a source B selector, default constant off.
// R6: Source B inversion per user output: 0 passes, 1 inverts; default 0.
// R7: User output joins A and B by AND (0) or OR (1); default OR.
// R8: Each direct output has a normal source selector with per-output default codes.
// R9: Normal source inversion per direct output: 0 passes, 1 inverts; default 0.
// R10: Direct output joins normal and composite by AND (0) or OR (1); default OR.
// R11: Direct output turn-off is delayed by 0 to 250 ms; default zero.
// R12: Inversions come before combining; results refresh every clock cycle.
module osc_top
    import osc_pkg::*;
#(
    parameter int unsigned P_NUM_SIG   = 256,
    parameter int unsigned P_MS_CYCLES = MS_CYCLES
)
(
    // Clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    // Internal status signals by code
    input  wire logic [P_NUM_SIG-1:0] i_status_sig,
    // AXI4-Lite write
    input  wire logic [7:0]           i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    // AXI4-Lite read
    input  wire logic [7:0]           i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    // Outputs
    output logic [NUM_DOUT-1:0]       o_dout,
    output logic [NUM_USR-1:0]        o_user_defined_output
);

    localparam int unsigned DIV_W = $clog2(P_MS_CYCLES + 1);

    function automatic logic pick(input logic [P_NUM_SIG-1:0] s, input logic [7:0] c);
        if (c == CODE_CONST_OFF || c == CODE_NO_FUNC || 32'(c) >= P_NUM_SIG)
            return 1'b0;
        return s[c];
    endfunction : pick

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int unsigned n);
        return (a[1:0] == 2'h0) && (a >= base) && (32'(a) < 32'(base) + 4 * n);
    endfunction : hit

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
            if (s[b])
                r[8*b +: 8] = d[8*b +: 8];
        return r;
    endfunction : merge

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Configuration and status storage
    logic [CFG_W-1:0] dout_cfg_ff [NUM_DOUT];
    logic [7:0]       dly_ff      [NUM_DOUT];
    logic [CFG_W-1:0] usr_cfg_ff  [NUM_USR];
    logic [NUM_USR-1:0] user_defined_output_ff;
    logic [NUM_DOUT-1:0] dout_dly;

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    logic        aw_full_ff, w_full_ff, bvalid_ff, awready_ff, wready_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic [1:0]  bresp_ff;

    wire aw_take     = i_awvalid & awready_ff;
    wire w_take      = i_wvalid & wready_ff;
    wire do_wr       = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire wr_dout     = hit(awaddr_ff, ADDR_DOUT_CFG, NUM_DOUT);
    wire wr_dly      = hit(awaddr_ff, ADDR_DOUT_DLY, NUM_DOUT);
    wire wr_usr      = hit(awaddr_ff, ADDR_USR_CFG, NUM_USR);
    wire wr_ok       = wr_dout | wr_dly | wr_usr | (awaddr_ff == ADDR_OUT_STAT);
    wire nxt_aw_full = (aw_full_ff & ~do_wr) | aw_take;
    wire nxt_w_full  = (w_full_ff & ~do_wr) | w_take;
    wire nxt_bvalid  = do_wr | (bvalid_ff & ~i_bready);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bresp_ff   <= RESP_OKAY;
        end
        else
        begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff  <= nxt_w_full;
            bvalid_ff  <= nxt_bvalid;
            awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_full & ~nxt_bvalid;
            if (aw_take)
                awaddr_ff <= i_awaddr;
            if (w_take)
            begin
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (do_wr)
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Setting registers
    generate
        for (genvar i = 0; i < NUM_DOUT; i++)
        begin : g_dout_reg
            wire        sel     = do_wr && awaddr_ff[4:2] == 3'(i);
            wire [31:0] nxt_cfg = merge(32'(dout_cfg_ff[i]), wdata_ff, wstrb_ff);
            wire [31:0] dly_wd  = merge(32'(dly_ff[i]), wdata_ff, wstrb_ff);
            wire [7:0]  wr_ms   = dly_wd[7:0];
            wire [7:0]  nxt_dly = (wr_ms > DLY_MAX_MS) ? DLY_MAX_MS : wr_ms;
            always_ff @(posedge i_mclk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    dout_cfg_ff[i] <= {3'b100, CODE_CONST_OFF, DOUT_NORM_RST[i]}; // [R1] [R2] [R8] [R9] [R10]
                    dly_ff[i]      <= DLY_RST;
                end
                else if (sel && wr_dout)
                    dout_cfg_ff[i] <= nxt_cfg[CFG_W-1:0];
                else if (sel && wr_dly)
                    dly_ff[i] <= nxt_dly; // [R11]
            end
        end
        for (genvar u = 0; u < NUM_USR; u++)
        begin : g_usr_reg
            wire [31:0] nxt_cfg = merge(32'(usr_cfg_ff[u]), wdata_ff, wstrb_ff);
            always_ff @(posedge i_mclk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    usr_cfg_ff[u] <= USR_CFG_RST; // [R3] [R4] [R5] [R6] [R7]
                else if (do_wr && wr_usr && awaddr_ff[2] == 1'(u))
                    usr_cfg_ff[u] <= nxt_cfg[CFG_W-1:0];
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    logic        rvalid_ff, arready_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    wire        ar_take    = i_arvalid & arready_ff;
    wire        rd_dout    = hit(i_araddr, ADDR_DOUT_CFG, NUM_DOUT);
    wire        rd_dly     = hit(i_araddr, ADDR_DOUT_DLY, NUM_DOUT);
    wire        rd_usr     = hit(i_araddr, ADDR_USR_CFG, NUM_USR);
    wire        rd_stat    = (i_araddr == ADDR_OUT_STAT);
    wire        nxt_rvalid = ar_take | (rvalid_ff & ~i_rready);
    logic [31:0] rd_word;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (rd_dout)
            rd_word = 32'(dout_cfg_ff[i_araddr[4:2]]);
        else if (rd_dly)
            rd_word = 32'(dly_ff[i_araddr[4:2]]);
        else if (rd_usr)
            rd_word = 32'(usr_cfg_ff[i_araddr[2]]);
        else if (rd_stat)
            rd_word = {22'h0, o_user_defined_output, 2'h0, o_dout};
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end
        else
        begin
            rvalid_ff  <= nxt_rvalid;
            arready_ff <= ~nxt_rvalid;
            if (ar_take)
            begin
                rdata_ff <= rd_word;
                rresp_ff <= (rd_dout | rd_dly | rd_usr | rd_stat) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Millisecond time base for the off delays
    logic [DIV_W-1:0] div_ff;
    logic             tick_ff;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (div_ff == DIV_W'(P_MS_CYCLES - 1));
            div_ff  <= (div_ff == DIV_W'(P_MS_CYCLES - 1)) ? '0 : div_ff + DIV_W'(1);
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Source selection and combining
    logic [NUM_DOUT-1:0] n_src, c_src, n_cond, c_cond, d_comb;
    logic [NUM_USR-1:0]  a_src, b_src, a_cond, b_cond, u_comb;

    generate
        for (genvar i = 0; i < NUM_DOUT; i++)
        begin : g_dout
            assign n_src[i]  = pick(i_status_sig, dout_cfg_ff[i][F_CODE0_LSB +: 8]); // [R8]
            assign c_src[i]  = pick(i_status_sig, dout_cfg_ff[i][F_CODE1_LSB +: 8]); // [R1]
            assign n_cond[i] = n_src[i] ^ dout_cfg_ff[i][F_INV0_BIT]; // [R9] [R12]
            assign c_cond[i] = c_src[i] ^ dout_cfg_ff[i][F_INV1_BIT]; // [R2] [R12]
            assign d_comb[i] = dout_cfg_ff[i][F_OP_BIT] ? (n_cond[i] | c_cond[i])
                                                        : (n_cond[i] & c_cond[i]); // [R10]
            osc_off_delay u_off_delay (
                .i_mclk     (i_mclk),
                .i_rst_n    (i_rst_n),
                .i_level    (d_comb[i]),
                .i_ms_tick  (tick_ff),
                .i_delay_ms (dly_ff[i]),
                .o_out      (dout_dly[i])
            );
        end
        for (genvar u = 0; u < NUM_USR; u++)
        begin : g_usr
            assign a_src[u]  = pick(i_status_sig, usr_cfg_ff[u][F_CODE0_LSB +: 8]); // [R3]
            assign b_src[u]  = pick(i_status_sig, usr_cfg_ff[u][F_USR_LSB +: 8]); // [R5]
            assign a_cond[u] = a_src[u] ^ usr_cfg_ff[u][F_INV0_BIT]; // [R4]
            assign b_cond[u] = b_src[u] ^ usr_cfg_ff[u][F_INV1_BIT]; // [R6]
            assign u_comb[u] = usr_cfg_ff[u][F_OP_BIT] ? (a_cond[u] | b_cond[u])
                                                       : (a_cond[u] & b_cond[u]); // [R7]
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            user_defined_output_ff <= '0;
        else
            user_defined_output_ff <= u_comb; // [R12]
    end

    assign o_awready             = awready_ff;
    assign o_wready              = wready_ff;
    assign o_bvalid              = bvalid_ff;
    assign o_bresp               = bresp_ff;
    assign o_arready             = arready_ff;
    assign o_rvalid              = rvalid_ff;
    assign o_rdata               = rdata_ff;
    assign o_rresp               = rresp_ff;
    assign o_dout                = dout_dly;
    assign o_user_defined_output = user_defined_output_ff;

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_d0_fall;
        $fell(d_comb[0]) && o_dout[0];
    endsequence

    property p_r1;  (dout_cfg_ff[0][F_CODE1_LSB +: 8] == CODE_CONST_OFF) |-> !c_src[0]; endproperty
    property p_r2;  c_cond[0] == (c_src[0] ^ dout_cfg_ff[0][F_INV1_BIT]); endproperty
    property p_r3;  (usr_cfg_ff[0][F_CODE0_LSB +: 8] == CODE_CONST_OFF) |-> !a_src[0]; endproperty
    property p_r4;  (a_src[0] && !usr_cfg_ff[0][F_INV0_BIT]) |-> a_cond[0]; endproperty
    property p_r5;  (usr_cfg_ff[1][F_USR_LSB +: 8] == CODE_CONST_OFF) |-> !b_src[1]; endproperty
    property p_r6;  (!b_src[0] && usr_cfg_ff[0][F_INV1_BIT]) |-> b_cond[0]; endproperty
    property p_r7;  (!usr_cfg_ff[0][F_OP_BIT] && !b_cond[0]) |=> !o_user_defined_output[0]; endproperty
    property p_r9;  (n_src[0] && dout_cfg_ff[0][F_INV0_BIT]) |-> !n_cond[0]; endproperty
    property p_r10; (dout_cfg_ff[0][F_OP_BIT] && n_cond[0]) |=> o_dout[0]; endproperty
    property p_r11; (s_d0_fall and (dly_ff[0] == 8'h00)) |=> !o_dout[0]; endproperty
    property p_r11b; (s_d0_fall and (dly_ff[0] != 8'h00)) |=> o_dout[0]; endproperty
    property p_r12; $rose(u_comb[1]) |=> o_user_defined_output[1] ##1 (o_user_defined_output[1] == $past(u_comb[1])); endproperty

    a_r1:   assert property (p_r1)   else $error("composite source not off at const-off code"); // [R1]
    a_r2:   assert property (p_r2)   else $error("composite inversion wrong"); // [R2]
    a_r3:   assert property (p_r3)   else $error("user source A not off at const-off code"); // [R3]
    a_r4:   assert property (p_r4)   else $error("user source A altered without inversion"); // [R4]
    a_r5:   assert property (p_r5)   else $error("user source B not off at const-off code"); // [R5]
    a_r6:   assert property (p_r6)   else $error("user source B not inverted"); // [R6]
    a_r7:   assert property (p_r7)   else $error("user AND combination wrong"); // [R7]
    a_r9:   assert property (p_r9)   else $error("normal inversion wrong"); // [R9]
    a_r10:  assert property (p_r10)  else $error("direct OR combination wrong"); // [R10]
    a_r11:  assert property (p_r11)  else $error("zero off delay not immediate"); // [R11]
    a_r11b: assert property (p_r11b) else $error("off delay ended early"); // [R11]
    a_r12:  assert property (p_r12)  else $error("user output not refreshed each cycle"); // [R12]

endmodule : osc_top

// [pkg/osc_pkg.sv]
package osc_pkg;

    // Source codes
    localparam logic [7:0] CODE_NO_FUNC   = 8'h00;
    localparam logic [7:0] CODE_CONST_OFF = 8'h80;

    // Output counts
    localparam int unsigned NUM_DOUT = 6;
    localparam int unsigned NUM_USR  = 2;

    // Register byte addresses
    localparam logic [7:0] ADDR_DOUT_CFG = 8'h00;
    localparam logic [7:0] ADDR_DOUT_DLY = 8'h20;
    localparam logic [7:0] ADDR_USR_CFG  = 8'h40;
    localparam logic [7:0] ADDR_OUT_STAT = 8'h50;

    // Configuration word layout (direct: normal/composite, user: A/B)
    localparam int unsigned CFG_W       = 19;
    localparam int unsigned F_CODE0_LSB = 0;
    localparam int unsigned F_CODE1_LSB = 8;
    localparam int unsigned F_INV0_BIT  = 16;
    localparam int unsigned F_INV1_BIT  = 17;
    localparam int unsigned F_OP_BIT    = 18;
    localparam int unsigned F_USR_LSB   = 8;

    // Values after reset
    localparam logic [7:0] DOUT_NORM_RST [0:5] = '{8'h90, 8'h8A, 8'h00, 8'h84, 8'h86, 8'h82};
    localparam logic [CFG_W-1:0] USR_CFG_RST = 19'h4_8080;
    localparam logic [7:0] DLY_RST           = 8'h00;
    localparam logic [7:0] DLY_MAX_MS        = 8'hFA;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Off-delay time base
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DLY_UNIT_NS   = 1000000;
    localparam int unsigned MS_CYCLES     = DLY_UNIT_NS / CLK_PERIOD_NS;

endpackage : osc_pkg

// [logic/osc_off_delay.sv]
`timescale 1ns/10ps
module osc_off_delay
    import osc_pkg::*;
(
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_level,
    input  wire logic       i_ms_tick,
    input  wire logic [7:0] i_delay_ms,
    // Delayed level
    output logic            o_out
);

    logic [7:0] cnt_ff;
    logic       out_ff;
    wire        expired = (cnt_ff >= i_delay_ms);

    // ON passes at once, OFF waits the programmed number of ms ticks
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_ff <= 8'h00;
            out_ff <= 1'b0;
        end
        else if (i_level)
        begin
            cnt_ff <= 8'h00;
            out_ff <= 1'b1;
        end
        else if (out_ff && expired)
            out_ff <= 1'b0; // [R11]
        else if (out_ff && i_ms_tick)
            cnt_ff <= cnt_ff + 8'h01;
    end

    assign o_out = out_ff;

endmodule : osc_off_delay

// [tb/test_osc_top.sv]
`timescale 1ns/10ps
module test_osc_top
    import osc_pkg::*;
;
    localparam int unsigned MSC = 10;
    logic         i_mclk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [255:0] i_status_sig;
    logic [7:0]   i_awaddr, i_araddr;
    logic [31:0]  i_wdata, o_rdata;
    logic [3:0]   i_wstrb;
    logic         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]   o_bresp, o_rresp, o_user_defined_output;
    logic [5:0]   o_dout;
    logic [31:0]  seed, rd, dcfg [0:5], ucfg [0:1];
    logic [1:0]   rsp;
    int           num_errors, comparisons;

    osc_top #(.P_NUM_SIG(256), .P_MS_CYCLES(MSC)) DUT (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_status_sig(i_status_sig),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_dout(o_dout), .o_user_defined_output(o_user_defined_output)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic pick(logic [255:0] s, logic [7:0] c);
        return (c == CODE_NO_FUNC || c == CODE_CONST_OFF) ? 1'b0 : s[c];
    endfunction : pick

    // Inversions first, then AND/OR
    function automatic logic comb(logic [255:0] s, logic [31:0] w);
        logic x, y;
        x = pick(s, w[7:0]) ^ w[16];
        y = pick(s, w[15:8]) ^ w[17];
        return w[18] ? (x | y) : (x & y);
    endfunction : comb

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int t;
        t = 0;
        i_awaddr  <= a;
        i_wdata   <= d;
        i_wstrb   <= s;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        forever
        begin
            @(posedge i_mclk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (i_bready && o_bvalid)
            begin
                r = o_bresp;
                i_bready <= 1'b0;
                break;
            end
            if (++t > 200)
            begin
                num_errors++;
                tally_and_finish();
            end
        end
        // One edge between transfers so bready is not set twice in one step
        @(posedge i_mclk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int t;
        t = 0;
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        forever
        begin
            @(posedge i_mclk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (i_rready && o_rvalid)
            begin
                d = o_rdata;
                r = o_rresp;
                i_rready <= 1'b0;
                break;
            end
            if (++t > 200)
            begin
                num_errors++;
                tally_and_finish();
            end
        end
        // One edge between transfers so rready is not set twice in one step
        @(posedge i_mclk);
    endtask : axi_read

    // New random status, then all outputs and the status word against the model
    task automatic check_outs();
        logic [255:0] s;
        logic [31:0]  st;
        s = {xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs()};
        i_status_sig <= s;
        repeat (4) @(posedge i_mclk);
        st = 32'h0;
        for (int n = 0; n < 6; n++) st[n] = comb(s, dcfg[n]);
        for (int u = 0; u < 2; u++) st[8+u] = comb(s, ucfg[u]);
        check("dout", {26'h0, o_dout}, {26'h0, st[5:0]});
        check("user_out", {30'h0, o_user_defined_output}, {30'h0, st[9:8]});
        axi_read(ADDR_OUT_STAT, rd, rsp);
        check("out_stat", rd, st);
    endtask : check_outs

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    initial
    begin
        #300000;
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        logic [7:0]  a;
        logic [31:0] w;
        seed = 32'd10421;
        num_errors = 0;
        comparisons = 0;
        {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        i_status_sig = '0;
        i_awaddr = 8'h00;
        i_araddr = 8'h00;
        i_wdata = 32'h0;
        i_wstrb = 4'hF;
        repeat (20) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        for (int n = 0; n < 6; n++)
        begin
            dcfg[n] = {13'h0, 1'b1, 2'b00, CODE_CONST_OFF, DOUT_NORM_RST[n]};
            axi_read(ADDR_DOUT_CFG + 8'(n * 4), rd, rsp);
            check("dout_cfg_rst", rd, dcfg[n]);
            axi_read(ADDR_DOUT_DLY + 8'(n * 4), rd, rsp);
            check("dly_rst", rd, {24'h0, DLY_RST});
        end
        for (int u = 0; u < 2; u++)
        begin
            ucfg[u] = {13'h0, USR_CFG_RST};
            axi_read(ADDR_USR_CFG + 8'(u * 4), rd, rsp);
            check("usr_cfg_rst", rd, ucfg[u]);
        end
        repeat (3) check_outs();
        // Unmapped place and read-only status word
        axi_write(8'h60, xs(), 4'hF, rsp);
        check("bad_wr_resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        axi_read(8'h60, rd, rsp);
        check("bad_rd_resp", {rd[29:0], rsp}, {30'h0, RESP_SLVERR});
        axi_write(ADDR_OUT_STAT, 32'hFFFF_FFFF, 4'hF, rsp);
        check("stat_wr_resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
        // Random configurations, every code width and both AND and OR
        for (int it = 0; it < 48; it++)
        begin
            w = xs() & 32'h0007_FFFF;
            if (it % 4 == 3)
            begin
                a = ADDR_USR_CFG + 8'(((it / 4) % 2) * 4);
                ucfg[(it / 4) % 2] = w;
            end
            else
            begin
                a = ADDR_DOUT_CFG + 8'((it % 6) * 4);
                dcfg[it % 6] = w;
            end
            axi_write(a, w, 4'hF, rsp);
            check("cfg_wr_resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
            axi_read(a, rd, rsp);
            check("cfg_rdback", rd, w);
            repeat (2) check_outs();
        end
        // Partial strobe keeps the other lanes
        w = xs();
        axi_write(ADDR_USR_CFG, w, 4'h1, rsp);
        ucfg[0] = {ucfg[0][31:8], w[7:0]};
        axi_read(ADDR_USR_CFG, rd, rsp);
        check("usr_cfg_strb", rd, ucfg[0]);
        check_outs();
        // Off delay of 3 ms on output 0, saturation at the maximum
        axi_write(ADDR_DOUT_DLY, 32'h0000_00FF, 4'hF, rsp);
        axi_read(ADDR_DOUT_DLY, rd, rsp);
        check("dly_sat", rd, {24'h0, DLY_MAX_MS});
        axi_write(ADDR_DOUT_DLY, 32'h0000_0003, 4'hF, rsp);
        axi_write(ADDR_DOUT_CFG, {13'h0, 1'b1, 2'b00, CODE_CONST_OFF, 8'h05}, 4'hF, rsp);
        i_status_sig <= 256'h20;
        repeat (4) @(posedge i_mclk);
        check("dly_on", {31'h0, o_dout[0]}, 32'h1);
        i_status_sig <= 256'h0;
        repeat (15) @(posedge i_mclk);
        check("dly_hold", {31'h0, o_dout[0]}, 32'h1);
        repeat (3 * MSC + 5 - 15) @(posedge i_mclk);
        check("dly_off", {31'h0, o_dout[0]}, 32'h0);
        tally_and_finish();
    end

endmodule : test_osc_top
